//--- logic/cmsi_monitor.sv
// clock monitor status capture and interrupt block with wishbone slave
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module cmsi_monitor
    import cmsi_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // status from the loop and reference monitors, same clock
    input wire cmsi_status_s liveStatus,
    // interrupt request
    output logic irq
);

    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    // live status one cycle old, the reference for edge events
    cmsi_status_s prevStatus;
    // low only during the first cycle after reset
    logic primed;

    // interrupt enables; reserved bits are stored as zero
    logic [7:0] maskMode;
    logic [7:0] maskLock;
    logic [7:0] maskRefA;
    logic [7:0] maskRefB;

    // snapshot of both live registers at the first event
    logic [7:0] captMain;
    logic [7:0] captRefs;

    //------------------------------------------------------------
    // bus decode
    //------------------------------------------------------------
    wire logic [9:0] regIdx = adr_i[11:2];
    wire logic busReq = cyc_i & stb_i;
    // a request is taken once; ack_o blocks a second take
    wire logic takeReq = busReq & ~ack_o;
    // a write lands on the edge where the master sees ack high
    wire logic wrEn = busReq & we_i & ack_o & sel_i[0];

    wire logic hitControl = (regIdx == IDX_CONTROL);
    wire logic hitLiveMain = (regIdx == IDX_LIVE_MAIN);
    wire logic hitLiveRefs = (regIdx == IDX_LIVE_REFS);
    wire logic hitCaptMain = (regIdx == IDX_CAPT_MAIN);
    wire logic hitCaptRefs = (regIdx == IDX_CAPT_REFS);
    wire logic hitMaskMode = (regIdx == IDX_MASK_MODE);
    wire logic hitMaskLock = (regIdx == IDX_MASK_LOCK);
    wire logic hitMaskRefA = (regIdx == IDX_MASK_REFERENCE_A);
    wire logic hitMaskRefB = (regIdx == IDX_MASK_REFERENCE_B);

    wire logic wrMode = wrEn & hitMaskMode;
    wire logic wrLock = wrEn & hitMaskLock;
    wire logic wrRefA = wrEn & hitMaskRefA;
    wire logic wrRefB = wrEn & hitMaskRefB;
    // the control bit is a pulse; nothing of it is stored
    wire logic irqReset = wrEn & hitControl
        & dat_i[CTRL_IRQ_RESET_BIT];

    //------------------------------------------------------------
    // live status layout
    //------------------------------------------------------------
    // both registers read straight from the inputs, no refresh step
    wire logic [7:0] liveMain = {
        1'b0,
        liveStatus.tooHigh,
        liveStatus.tooLow,
        liveStatus.estDone,
        liveStatus.reference_b,
        liveStatus.holdover,
        liveStatus.phaseLock,
        liveStatus.freqLock
    };
    // lock decisions are made by the detectors outside this block
    wire logic [7:0] liveRefs = {
        1'b0,
        liveStatus.refAValid,
        liveStatus.refALoss,
        liveStatus.refAOol,
        1'b0,
        liveStatus.refBValid,
        liveStatus.refBLoss,
        liveStatus.refBOol
    };

    //------------------------------------------------------------
    // status history
    //------------------------------------------------------------
    wire logic [7:0] prevMain = {
        1'b0,
        prevStatus.tooHigh,
        prevStatus.tooLow,
        prevStatus.estDone,
        prevStatus.reference_b,
        prevStatus.holdover,
        prevStatus.phaseLock,
        prevStatus.freqLock
    };
    wire logic [7:0] prevRefs = {
        1'b0,
        prevStatus.refAValid,
        prevStatus.refALoss,
        prevStatus.refAOol,
        1'b0,
        prevStatus.refBValid,
        prevStatus.refBLoss,
        prevStatus.refBOol
    };

    //------------------------------------------------------------
    // edge events
    //------------------------------------------------------------
    wire logic [7:0] riseMain = liveMain & ~prevMain;
    wire logic [7:0] fallMain = ~liveMain & prevMain;
    wire logic [7:0] riseRefs = liveRefs & ~prevRefs;
    wire logic [7:0] fallRefs = ~liveRefs & prevRefs;

    // named events of the main register
    wire logic estDoneRise = riseMain[4];
    wire logic phaseFall = fallMain[1];
    wire logic phaseRise = riseMain[1];
    wire logic freqFall = fallMain[0];
    wire logic freqRise = riseMain[0];
    wire logic holdLeave = fallMain[2];
    wire logic holdEnter = riseMain[2];
    // either edge of the selection bit is a change of reference
    wire logic refChange = riseMain[3] | fallMain[3];

    wire logic [7:0] evMode = {5'h00, refChange, holdLeave, holdEnter};
    wire logic [7:0] evLock = {3'h0, estDoneRise, phaseFall, phaseRise,
        freqFall, freqRise};

    // per reference: valid, loss and out-of-limit edges in mask order
    logic [7:0] evRef [2];
    for (genvar r = 0; r < 2; r++)
    begin : g_ref_events
        // lowest bit of this reference; loss and valid sit above it
        localparam int BASE = 4 - 4 * r;
        wire logic validRise = riseRefs[BASE + 2];
        wire logic validFall = fallRefs[BASE + 2];
        wire logic lossRise = riseRefs[BASE + 1];
        wire logic lossFall = fallRefs[BASE + 1];
        wire logic limitRise = riseRefs[BASE];
        wire logic limitFall = fallRefs[BASE];
        assign evRef[r] = {2'h0, validRise, validFall, lossRise, lossFall,
            limitRise, limitFall};
    end
    wire logic [7:0] evRefA = evRef[0];
    wire logic [7:0] evRefB = evRef[1];

    //------------------------------------------------------------
    // interrupt decision
    //------------------------------------------------------------
    wire logic fireMode = |(evMode & maskMode);
    wire logic fireLock = |(evLock & maskLock);
    wire logic fireRefA = |(evRefA & maskRefA);
    wire logic fireRefB = |(evRefB & maskRefB);
    // no events in the first cycle: prevStatus is still the reset value
    wire logic fire = primed
        & (fireMode | fireLock | fireRefA | fireRefB);

    // a new event in the clearing cycle wins and re-arms the capture
    wire logic next_irq = fire | (irq & ~irqReset);
    wire logic capture = fire & (~irq | irqReset);

    //------------------------------------------------------------
    // read mux
    //------------------------------------------------------------
    // one select at most is high, so the lanes are simply ORed
    wire logic [7:0] readByte =
        ({8{hitLiveMain}} & liveMain)
        | ({8{hitLiveRefs}} & liveRefs)
        | ({8{hitCaptMain}} & captMain)
        | ({8{hitCaptRefs}} & captRefs)
        | ({8{hitMaskMode}} & maskMode)
        | ({8{hitMaskLock}} & maskLock)
        | ({8{hitMaskRefA}} & maskRefA)
        | ({8{hitMaskRefB}} & maskRefB);

    //------------------------------------------------------------
    // bus answer
    //------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ack_o <= 1'b0;
        end
        else
        begin
            ack_o <= takeReq;
        end
    end

    //------------------------------------------------------------
    // read data
    //------------------------------------------------------------
    // read data stands until the next request is taken
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            dat_o <= 32'h0000_0000;
        end
        else if (takeReq)
        begin
            dat_o <= {24'h00_0000, readByte};
        end
    end

    //------------------------------------------------------------
    // mask registers
    //------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            maskMode <= MASK_RESET;
        end
        else if (wrMode)
        begin
            maskMode <= dat_i[7:0] & MASK_MODE_BITS;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            maskLock <= MASK_RESET;
        end
        else if (wrLock)
        begin
            maskLock <= dat_i[7:0] & MASK_LOCK_BITS;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            maskRefA <= MASK_RESET;
        end
        else if (wrRefA)
        begin
            maskRefA <= dat_i[7:0] & MASK_REF_BITS;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            maskRefB <= MASK_RESET;
        end
        else if (wrRefB)
        begin
            maskRefB <= dat_i[7:0] & MASK_REF_BITS;
        end
    end

    //------------------------------------------------------------
    // status history register
    //------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            prevStatus <= STATUS_RESET;
            primed <= 1'b0;
        end
        else
        begin
            prevStatus <= liveStatus;
            primed <= 1'b1;
        end
    end

    //------------------------------------------------------------
    // interrupt
    //------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= next_irq;
        end
    end

    //------------------------------------------------------------
    // capture
    //------------------------------------------------------------
    // first event wins; later events wait for the interrupt reset
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            captMain <= CAPT_RESET;
        end
        else if (capture)
        begin
            captMain <= liveMain;
        end
        else if (irqReset)
        begin
            captMain <= CAPT_RESET;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            captRefs <= CAPT_RESET;
        end
        else if (capture)
        begin
            captRefs <= liveRefs;
        end
        else if (irqReset)
        begin
            captRefs <= CAPT_RESET;
        end
    end

endmodule // cmsi_monitor

`default_nettype wire

//--- logic/cmsi_pkg.sv
// constants, register map and status carrier of the clock monitor block
//------------------------------------------------------------
// What this block does
// - live main status register is read-only and always shows current conditions
// - bit 6 flags estimator frequency too high, bit 5 too low
// - bit 4 is true once the estimator has finished successfully
// - bit 3 reads 0 for reference A active, 1 for reference B
// - bit 2 is set while the digital loop is in holdover
// - bit 1 reports phase lock from the phase lock detector
// - bit 0 reports frequency lock; may differ from phase lock
// - reference status bits 6..4: A valid, A loss, A out of limits
// - reference status bits 2..0: B valid, B loss, B out of limits
// - captured status registers hold both live registers at interrupt time
// - captured bits hold until the interrupt reset control bit clears them
// - mode mask bit 2 interrupts on an active reference change
// - mode mask bit 1 on holdover exit, bit 0 on holdover entry
// - lock mask bit 4 interrupts when the estimator completes
// - lock mask bit 3 on phase lock fall, bit 2 on its rise
// - lock mask bit 1 on frequency lock fall, bit 0 on its rise
// - reference masks interrupt on edges of valid, loss, out-of-limit per reference
//------------------------------------------------------------
`default_nettype none

package cmsi_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CONTROL = 10'h012;
    localparam logic [9:0] IDX_LIVE_MAIN = 10'h300;
    localparam logic [9:0] IDX_LIVE_REFS = 10'h301;
    localparam logic [9:0] IDX_CAPT_MAIN = 10'h302;
    localparam logic [9:0] IDX_CAPT_REFS = 10'h303;
    localparam logic [9:0] IDX_MASK_MODE = 10'h304;
    localparam logic [9:0] IDX_MASK_LOCK = 10'h305;
    localparam logic [9:0] IDX_MASK_REFERENCE_A = 10'h306;
    localparam logic [9:0] IDX_MASK_REFERENCE_B = 10'h307;

    localparam int CTRL_IRQ_RESET_BIT = 5;

    // writable bits of each mask register, others reserved and read zero
    localparam logic [7:0] MASK_MODE_BITS = 8'h07;
    localparam logic [7:0] MASK_LOCK_BITS = 8'h1F;
    localparam logic [7:0] MASK_REF_BITS = 8'h3F;

    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] CAPT_RESET = 8'h00;

    typedef struct packed {
        logic tooHigh;
        logic tooLow;
        logic estDone;
        logic reference_b;
        logic holdover;
        logic phaseLock;
        logic freqLock;
        logic refAValid;
        logic refALoss;
        logic refAOol;
        logic refBValid;
        logic refBLoss;
        logic refBOol;
    } cmsi_status_s;

    localparam cmsi_status_s STATUS_RESET = '0;

endpackage

`default_nettype wire

//--- sim/cmsi_chk_monitor.sv
// port checker for the clock monitor status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module cmsi_chk
    import cmsi_pkg::*;
#(parameter int ADDR_W = 12)(
    // watched ports
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire cmsi_status_s liveStatus,
    input wire logic irq
);
//----
// relations
//----
wire req = cyc_i && stb_i && !ack_o;
wire rdMain = req && !we_i && adr_i[11:2] == IDX_LIVE_MAIN;
wire rdRefs = req && !we_i && adr_i[11:2] == IDX_LIVE_REFS;
wire clr = cyc_i && stb_i && we_i && ack_o && sel_i[0] && dat_i[5]
    && adr_i[11:2] == IDX_CONTROL;
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
a_ack_answer: assert property (req |=> ack_o) else $error("no ack");
a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("long ack");
a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
a_main_live: assert property (rdMain |=> dat_o[7:0] ==
    {1'b0, $past(liveStatus[12:6])}) else $error("main status");
a_refs_live: assert property (rdRefs |=> dat_o[7:0] == {1'b0,
    $past(liveStatus[5:3]), 1'b0, $past(liveStatus[2:0])})
    else $error("reference status");
a_irq_holds: assert property (irq && !clr |=> irq)
    else $error("irq dropped");
a_irq_clear: assert property (clr && $stable(liveStatus) |=> !irq)
    else $error("irq not cleared");
a_irq_cause: assert property (!irq && $stable(liveStatus) |=> !irq)
    else $error("irq without event");
c_irq_rise: cover property ($rose(irq));
c_clear: cover property (clr && irq);
c_read: cover property (rdRefs);
endmodule // cmsi_chk
`default_nettype wire

//--- sim/cmsi_monitor_tb_top.sv
// self-checking bench for the clock monitor status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module cmsi_monitor_tb_top;
import cmsi_pkg::*;
logic ref_clk = 1'b0;
logic rst = 1'b1;
logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
logic [11:0] adr = 12'h000;
logic [3:0] sel = 4'h0;
logic [31:0] dat = 32'h0, datO;
logic [7:0] rd;
cmsi_status_s lv = STATUS_RESET;
int num_errors = 0, checks = 0, ticks = 0;
cmsi_monitor #(.ADDR_W(12)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(datO), .ack_o(ack), .liveStatus(lv), .irq(irq));
always #10 ref_clk = ~ref_clk;
//----
// helpers
//----
task automatic conclude();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
        num_errors++;
        $display("mismatch %s expected %h seen %h", nm, e, g);
    end
endtask
// holds the request until ack; only the bench timeout ends the wait
task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge ref_clk);
    {cyc, stb, we, sel} <= {2'b11, w, 4'hF};
    adr <= {i, 2'b00};
    dat <= {24'h0, d};
    do
    begin
        @(posedge ref_clk);
    end
    while (ack !== 1'b1);
    q = datO[7:0];
    {cyc, stb} <= 2'b00;
endtask
function automatic logic [7:0] mainOf(input cmsi_status_s s);
    return {1'b0, s[12:6]};
endfunction
function automatic logic [7:0] refsOf(input cmsi_status_s s);
    return {1'b0, s[5:3], 1'b0, s[2:0]};
endfunction
//----
// scenarios
//----
task automatic s_reset_vals();
    chk("irq", 8'h00, {7'h0, irq});
    for (int i = 'h302; i < 'h306; i++)
    begin
        wb(1'b0, i[9:0], 8'h00, rd);
        chk("reset value", 8'h00, rd);
    end
endtask
task automatic s_masks();
    wb(1'b1, IDX_MASK_MODE, 8'hFF, rd);
    wb(1'b1, IDX_MASK_LOCK, 8'hFF, rd);
    wb(1'b1, IDX_LIVE_MAIN, 8'hFF, rd);
    wb(1'b0, IDX_MASK_MODE, 8'h00, rd);
    chk("mode mask", 8'h07, rd);
    wb(1'b0, IDX_MASK_LOCK, 8'h00, rd);
    chk("lock mask", 8'h1F, rd);
    wb(1'b0, IDX_LIVE_MAIN, 8'h00, rd);
    chk("main ro", mainOf(lv), rd);
    wb(1'b0, 10'h3FF, 8'h00, rd);
    chk("unmapped", 8'h00, rd);
    wb(1'b1, IDX_MASK_MODE, 8'h00, rd);
    wb(1'b1, IDX_MASK_LOCK, 8'h00, rd);
endtask
task automatic s_live();
    for (int b = 0; b < 13; b++)
    begin
        lv <= cmsi_status_s'(13'h0001 << b);
        wb(1'b0, IDX_LIVE_MAIN, 8'h00, rd);
        chk("live main", mainOf(lv), rd);
        wb(1'b0, IDX_LIVE_REFS, 8'h00, rd);
        chk("live refs", refsOf(lv), rd);
    end
    lv <= STATUS_RESET;
endtask
// one enabled edge fires, is captured, cleared, the other edge is tried
task automatic ev(input logic [9:0] idx, input int m, input int sb,
    input logic rise, input logic both);
    lv[sb] <= !rise;
    wb(1'b1, idx, 8'h01 << m, rd);
    wb(1'b1, IDX_CONTROL, 8'h20, rd);
    // the clear lands on the edge that ends the write
    @(posedge ref_clk);
    chk("irq idle", 8'h00, {7'h0, irq});
    lv[sb] <= rise;
    repeat (2) @(posedge ref_clk);
    chk("irq fired", 8'h01, {7'h0, irq});
    wb(1'b0, IDX_CAPT_MAIN, 8'h00, rd);
    chk("capt main", mainOf(lv), rd);
    wb(1'b0, IDX_CAPT_REFS, 8'h00, rd);
    chk("capt refs", refsOf(lv), rd);
    wb(1'b1, IDX_CONTROL, 8'h20, rd);
    wb(1'b0, IDX_CAPT_REFS, 8'h00, rd);
    chk("capt cleared", 8'h00, rd);
    lv[sb] <= !rise;
    repeat (2) @(posedge ref_clk);
    chk("other edge", {7'h0, both}, {7'h0, irq});
endtask
task automatic s_events();
    for (int m = 0; m < 6; m++)
    begin
        ev(IDX_MASK_REFERENCE_A, m, 5 - (5 - m) / 2, m[0], 1'b0);
        ev(IDX_MASK_REFERENCE_B, m, 2 - (5 - m) / 2, m[0], 1'b0);
    end
    for (int m = 0; m < 4; m++)
        ev(IDX_MASK_LOCK, m, 6 + m / 2, !m[0], 1'b0);
    ev(IDX_MASK_LOCK, 4, 10, 1'b1, 1'b0);
    ev(IDX_MASK_MODE, 0, 8, 1'b1, 1'b0);
    ev(IDX_MASK_MODE, 1, 8, 1'b0, 1'b0);
    ev(IDX_MASK_MODE, 2, 9, 1'b1, 1'b1);
endtask
initial
begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    s_reset_vals();
    s_masks();
    s_live();
    s_events();
    conclude();
end
// the full run needs about 600 cycles
always @(posedge ref_clk)
begin
    ticks <= ticks + 1;
    if (ticks == 8000)
    begin
        num_errors++;
        conclude();
    end
end
endmodule // cmsi_monitor_tb_top
bind cmsi_monitor cmsi_chk #(.ADDR_W(ADDR_W)) u_chk (.ref_clk(ref_clk),
    .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .liveStatus(liveStatus), .irq(irq));
`default_nettype wire
